/* File: include/exc_unit_consts.vh */
// constants shared by the exception unit and its conflict detector
`ifndef EXC_UNIT_CONSTS_VH
`define EXC_UNIT_CONSTS_VH

// ==========================================================================
// register byte offsets
`define OFS_TASK_STATE      8'h00
`define OFS_RETURN_PTR      8'h04
`define OFS_REPORT          8'h08
`define OFS_FLAGS           8'h0C
`define OFS_CLEAR           8'h10
`define OFS_VECTOR_PTR      8'h14
`define OFS_CONTROL         8'h18
`define OFS_IRQ_STATUS      8'h1C
`define OFS_IRQ_MASK        8'h20

// ==========================================================================
// task state copy layout
`define TS_WIDTH            16
`define TS_CXM_LSB          0
`define TS_CXM_MSB          1
`define TS_IB_BIT           2
`define TS_LOOP_BUFFER_ACTIVE_BIT_BIT         3
`define TS_INT_BIT          4
`define TS_RESET            16'h0000
`define TS_CXM_ZERO         2'h0

// ==========================================================================
// report, flag and clear fields
`define REPORT_RCX_BIT      1
`define FLAG_IXF_BIT        1
`define CLEAR_IXF_VALUE     32'h0000_0002
`define RETURN_MASK         32'hFFFF_FE1F
`define VEC_NUM_LSB         5
`define VEC_NUM_MSB         8

// ==========================================================================
// control and interrupt layout
`define CTRL_LEGACY_BIT     0
`define IRQ_EXC_BIT         0
`define IRQ_RESUME_BIT      1
`define IRQ_EARLY_BIT       2
`define IRQ_WIDTH           3

// ==========================================================================
// bus answers and counts
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`define LOOP_MIN_GAP        2'h2
`define DRAIN_DEFAULT       4'h5

`endif

/* File: hdl/conflict_detect.v */
// multiple-write conflict detector over the retiring write slots
`timescale 1ns/100ps
`include "exc_unit_consts.vh"

module conflict_detect #(
    parameter SLOTS = 4,
    parameter RW    = 6
) (
    // clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    // retiring writes
    input  wire [SLOTS-1:0]    wr_valid,
    input  wire [SLOTS*RW-1:0] wr_dest,
    input  wire [SLOTS-1:0]    wr_annul,
    input  wire [SLOTS-1:0]    wr_pred_annul,
    // mode and result
    input  wire              legacy,
    output reg               conflict
);

    // ======================================================================
    // slot qualification
    // legacy mode still counts annulled writes whose predicates came from
    // an annulled packet; the corrected mode drops every annulled slot
    function counts;
        input v;
        input a;
        input p;
        input lg;
        begin
            counts = v & (~a | (lg & p));
        end
    endfunction

    reg      hit;
    integer  i;
    integer  j;

    // ======================================================================
    // pairwise compare
    always @* begin
        hit = 1'b0;
        for (i = 0; i < SLOTS; i = i + 1) begin
            for (j = i + 1; j < SLOTS; j = j + 1) begin
                if (counts(wr_valid[i], wr_annul[i], wr_pred_annul[i], legacy) &&
                    counts(wr_valid[j], wr_annul[j], wr_pred_annul[j], legacy) &&
                    (wr_dest[i*RW +: RW] == wr_dest[j*RW +: RW])) begin
                    hit = 1'b1;
                end
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            conflict <= 1'b0;
        end else begin
            conflict <= hit;
        end
    end

endmodule // conflict_detect

/* File: hdl/exc_unit.v */
// interrupt drain, exception capture and loop resume unit with register slave
`timescale 1ns/100ps
`include "exc_unit_consts.vh"

module exc_unit #(
    parameter SLOTS = 4,
    parameter RW    = 6,
    parameter [3:0] DRAIN_CYCLES = `DRAIN_DEFAULT
) (
    // clock and reset
    input  wire                aclk,
    input  wire                aresetn,
    // register bus write
    input  wire [7:0]          s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output reg                 s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output reg                 s_axi_wready,
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    // register bus read
    input  wire [7:0]          s_axi_araddr,
    input  wire                s_axi_arvalid,
    output reg                 s_axi_arready,
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready,
    // core state
    input  wire                int_req,
    input  wire [3:0]          int_num,
    input  wire                int_return,
    input  wire [31:0]         pc,
    input  wire [`TS_WIDTH-1:0] task_state,
    // retiring writes
    input  wire [SLOTS-1:0]    wr_valid,
    input  wire [SLOTS*RW-1:0] wr_dest,
    input  wire [SLOTS-1:0]    wr_annul,
    input  wire [SLOTS-1:0]    wr_pred_annul,
    // loop tracking
    input  wire                loop_active,
    input  wire                loop_kernel_marker,
    input  wire                loop_start,
    input  wire                packet_issue,
    // outputs to core
    output reg                 annul,
    output reg                 handler_enter,
    output reg                 exc_take,
    output reg                 loop_resume,
    output reg                 loop_early_exit,
    output reg                 irq
);

    // ======================================================================
    // states
    localparam [2:0] ST_RUN     = 3'b001;
    localparam [2:0] ST_DRAIN   = 3'b010;
    localparam [2:0] ST_HANDLER = 3'b100;

    reg  [2:0]            state;
    reg  [3:0]            drain_cnt;
    reg                   exc_pending;
    reg  [`TS_WIDTH-1:0]  nmi_task_state_copy;
    reg  [31:0]           nmi_return_pointer;
    reg  [31:0]           internal_exception_report;
    reg  [31:0]           exception_flag_register;
    reg  [31:0]           vector_table_pointer;
    reg  [31:0]           control;
    reg  [`IRQ_WIDTH-1:0] irq_status;
    reg  [`IRQ_WIDTH-1:0] irq_mask;
    reg                   loop_int_pending;
    reg  [1:0]            gap_cnt;
    reg                   gap_valid;
    reg                   aw_got;
    reg                   w_got;
    reg  [7:0]            aw_addr;
    reg  [31:0]           w_data;
    wire                  conflict;
    wire                  legacy;
    wire                  wr_do;
    wire                  rd_do;
    wire                  rd_clear;
    wire                  clear_ixf;
    wire                  take_now;
    wire                  take_late;
    wire                  early;
    wire [`IRQ_WIDTH-1:0] irq_set;
    reg  [31:0]           rd_mux;
    reg                   rd_hit;

    assign legacy = control[`CTRL_LEGACY_BIT];

    // ======================================================================
    // conflict detector
    conflict_detect #(
        .SLOTS (SLOTS),
        .RW    (RW)
    ) u_conflict (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .wr_valid      (wr_valid),
        .wr_dest       (wr_dest),
        .wr_annul      (wr_annul),
        .wr_pred_annul (wr_pred_annul),
        .legacy        (legacy),
        .conflict      (conflict)
    );

    // handler fetch address: vector base with interrupt number in 8:5
    function [31:0] handler_addr;
        input [31:0] base;
        input [3:0]  num;
        begin
            handler_addr = base;
            handler_addr[`VEC_NUM_MSB:`VEC_NUM_LSB] = num;
        end
    endfunction

    // ======================================================================
    // drain and exception sequencing
    // a conflict seen while draining waits for the handler entry so the
    // saved state names the handler, not an annulled packet
    assign take_now  = conflict && (state == ST_RUN);
    assign take_late = (exc_pending || conflict) && (state == ST_DRAIN) &&
                       (drain_cnt == 4'h0);

    always @(posedge aclk) begin
        if (!aresetn) begin
            state         <= ST_RUN;
            drain_cnt     <= 4'h0;
            annul         <= 1'b0;
            handler_enter <= 1'b0;
            exc_pending   <= 1'b0;
        end else begin
            handler_enter <= 1'b0;
            case (state)
                ST_RUN: begin
                    if (int_req) begin
                        state     <= ST_DRAIN;
                        drain_cnt <= DRAIN_CYCLES - 4'h1;
                        annul     <= 1'b1;
                    end
                end
                ST_DRAIN: begin
                    if (conflict) begin
                        exc_pending <= 1'b1;
                    end
                    if (drain_cnt == 4'h0) begin
                        state         <= ST_HANDLER;
                        annul         <= 1'b0;
                        handler_enter <= 1'b1;
                        exc_pending   <= 1'b0;
                    end else begin
                        drain_cnt <= drain_cnt - 4'h1;
                    end
                end
                ST_HANDLER: begin
                    // handler flow is untouched; return goes back unchanged
                    if (int_return) begin
                        state <= ST_RUN;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // ======================================================================
    // exception capture
    always @(posedge aclk) begin
        if (!aresetn) begin
            exc_take                  <= 1'b0;
            nmi_task_state_copy       <= `TS_RESET;
            nmi_return_pointer        <= 32'h0000_0000;
            internal_exception_report <= 32'h0000_0000;
        end else begin
            exc_take <= take_now | take_late;
            if (take_late) begin
                nmi_task_state_copy <= `TS_RESET;
                nmi_task_state_copy[`TS_INT_BIT] <= 1'b1;
                nmi_task_state_copy[`TS_CXM_MSB:`TS_CXM_LSB] <= `TS_CXM_ZERO;
                nmi_return_pointer <= handler_addr(vector_table_pointer, int_num);
            end else if (take_now) begin
                nmi_task_state_copy <= task_state;
                nmi_return_pointer  <= pc;
            end
            if (take_now || take_late) begin
                internal_exception_report <= 32'h0000_0000;
                internal_exception_report[`REPORT_RCX_BIT] <= 1'b1;
            end
        end
    end

    // flag: a new exception wins over a clear in the same cycle
    assign clear_ixf = wr_do && (aw_addr == `OFS_CLEAR) &&
                       (w_data == `CLEAR_IXF_VALUE);

    always @(posedge aclk) begin
        if (!aresetn) begin
            exception_flag_register <= 32'h0000_0000;
        end else if (take_now || take_late) begin
            exception_flag_register <= 32'h0000_0000;
            exception_flag_register[`FLAG_IXF_BIT] <= 1'b1;
        end else if (clear_ixf) begin
            exception_flag_register[`FLAG_IXF_BIT] <= 1'b0;
        end
    end

    // ======================================================================
    // software-pipelined loop resume
    // legacy: a loop start fewer than two packets after the kernel marker
    // drops the pending resume, which code spacing avoids
    assign early = legacy && loop_int_pending && loop_start &&
                   gap_valid && (gap_cnt < `LOOP_MIN_GAP);

    always @(posedge aclk) begin
        if (!aresetn) begin
            loop_int_pending <= 1'b0;
            gap_cnt          <= 2'h0;
            gap_valid        <= 1'b0;
            loop_resume      <= 1'b0;
            loop_early_exit  <= 1'b0;
        end else begin
            loop_resume     <= 1'b0;
            loop_early_exit <= early;
            if (loop_kernel_marker) begin
                gap_cnt   <= 2'h0;
                gap_valid <= 1'b1;
            end else if (loop_start) begin
                gap_valid <= 1'b0;
            end else if (packet_issue && gap_cnt != `LOOP_MIN_GAP) begin
                gap_cnt <= gap_cnt + 2'h1;
            end
            if (early) begin
                loop_int_pending <= 1'b0;
            end else if (state == ST_RUN && int_req && loop_active) begin
                loop_int_pending <= 1'b1;
            end else if (state == ST_HANDLER && int_return && loop_int_pending) begin
                loop_int_pending <= 1'b0;
                loop_resume      <= 1'b1;
            end
        end
    end

    // ======================================================================
    // interrupt status, read clears, set wins
    assign irq_set  = {loop_early_exit, loop_resume, exc_take};
    assign rd_clear = rd_do && (s_axi_araddr == `OFS_IRQ_STATUS);

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= {`IRQ_WIDTH{1'b0}};
            irq        <= 1'b0;
        end else begin
            irq_status <= (rd_clear ? {`IRQ_WIDTH{1'b0}} : irq_status) | irq_set;
            irq        <= |(irq_status & irq_mask);
        end
    end

    // ======================================================================
    // register bus write channel
    assign wr_do = aw_got && w_got && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready        <= 1'b0;
            s_axi_wready         <= 1'b0;
            s_axi_bvalid         <= 1'b0;
            s_axi_bresp          <= `RESP_OKAY;
            aw_got               <= 1'b0;
            w_got                <= 1'b0;
            aw_addr              <= 8'h00;
            w_data               <= 32'h0000_0000;
            vector_table_pointer <= 32'h0000_0000;
            control              <= 32'h0000_0000;
            irq_mask             <= {`IRQ_WIDTH{1'b0}};
        end else begin
            s_axi_awready <= !aw_got && !(s_axi_awvalid && s_axi_awready) && !wr_do;
            s_axi_wready  <= !w_got && !(s_axi_wvalid && s_axi_wready) && !wr_do;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_do) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                // byte strobes ignored: every register is written whole
                case (aw_addr)
                    `OFS_VECTOR_PTR: vector_table_pointer <= w_data;
                    `OFS_CONTROL:    control              <= w_data;
                    `OFS_IRQ_MASK:   irq_mask             <= w_data[`IRQ_WIDTH-1:0];
                    `OFS_CLEAR:      control              <= control;
                    default:         s_axi_bresp          <= `RESP_SLVERR;
                endcase
            end
        end
    end

    // ======================================================================
    // register bus read channel
    assign rd_do = s_axi_arvalid && s_axi_arready;

    always @* begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            `OFS_TASK_STATE: rd_mux[`TS_WIDTH-1:0] = nmi_task_state_copy;
            `OFS_RETURN_PTR: rd_mux = nmi_return_pointer;
            `OFS_REPORT:     rd_mux = internal_exception_report;
            `OFS_FLAGS:      rd_mux = exception_flag_register;
            `OFS_CLEAR:      rd_mux = 32'h0000_0000;
            `OFS_VECTOR_PTR: rd_mux = vector_table_pointer;
            `OFS_CONTROL:    rd_mux = control;
            `OFS_IRQ_STATUS: rd_mux[`IRQ_WIDTH-1:0] = irq_status;
            `OFS_IRQ_MASK:   rd_mux[`IRQ_WIDTH-1:0] = irq_mask;
            default:         rd_hit = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_do;
            if (rd_do) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // exc_unit

/* File: tb/exc_unit_checker.sv */
// assertion checker for the exception unit ports
`timescale 1ns/100ps
`include "exc_unit_consts.vh"

// ==========================================================================
// checker
module exc_unit_checker #(
    parameter SLOTS = 4,
    parameter RW    = 6,
    parameter [3:0] DRAIN_CYCLES = `DRAIN_DEFAULT
) (
    // clock and reset
    input wire                aclk,
    input wire                aresetn,
    // register bus
    input wire                s_axi_awvalid,
    input wire                s_axi_awready,
    input wire                s_axi_wvalid,
    input wire                s_axi_wready,
    input wire [1:0]          s_axi_bresp,
    input wire                s_axi_bvalid,
    input wire                s_axi_bready,
    input wire                s_axi_arvalid,
    input wire                s_axi_arready,
    input wire [31:0]         s_axi_rdata,
    input wire                s_axi_rvalid,
    input wire                s_axi_rready,
    // core side
    input wire                int_req,
    input wire [SLOTS-1:0]    wr_valid,
    input wire [SLOTS*RW-1:0] wr_dest,
    input wire [SLOTS-1:0]    wr_annul,
    input wire [SLOTS-1:0]    wr_pred_annul,
    input wire                annul,
    input wire                handler_enter,
    input wire                exc_take
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // drain is counted here, a repetition would need a fixed count
    reg [3:0] run_len;
    always @(posedge aclk) begin
        if (!aresetn || !annul)
            run_len <= 4'h0;
        else
            run_len <= run_len + 4'h1;
    end

    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_run_conflict;
        !annul && !int_req && !handler_enter && (wr_valid[1:0] == 2'h3) && !(|wr_annul) &&
        !(|wr_pred_annul) && (wr_dest[RW-1:0] == wr_dest[2*RW-1:RW]);
    endsequence
    sequence s_drain_end;
        !annul ##0 handler_enter;
    endsequence

    a_drain_length: assert property ($fell(annul) |-> run_len == DRAIN_CYCLES)
        else $error("drain length differs");
    a_enter_at_end: assert property ($fell(annul) |-> s_drain_end)
        else $error("no handler entry at drain end");
    a_enter_cause: assert property (handler_enter |-> $past(annul))
        else $error("handler entry without drain");
    a_drain_exc: assert property (exc_take && $past(annul) |-> handler_enter)
        else $error("drain exception not at handler entry");
    a_run_exc: assert property (s_run_conflict |-> ##2 exc_take)
        else $error("conflict did not raise exception");
    a_enter_pulse: assert property (handler_enter |=> !handler_enter)
        else $error("handler entry longer than one cycle");
    a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule // exc_unit_checker

bind exc_unit exc_unit_checker #(
    .SLOTS(SLOTS), .RW(RW), .DRAIN_CYCLES(DRAIN_CYCLES)
) chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .int_req, .wr_valid, .wr_dest,
    .wr_annul, .wr_pred_annul, .annul, .handler_enter, .exc_take
);

/* File: tb/tb_exc_unit.sv */
// self-checking testbench for the exception unit
`timescale 1ns/100ps
`include "exc_unit_consts.vh"

// ==========================================================================
// bench
module tb_exc_unit;
    localparam [3:0]  DC  = 4'h4;
    localparam [31:0] VEC = 32'hABCD_1200;
    // stimulus
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg  [31:0] s_axi_wdata = 32'h0, pc = 32'h0000_0404;
    reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg         int_req = 1'b0, int_return = 1'b0, loop_active = 1'b0, loop_start = 1'b0;
    reg         loop_kernel_marker = 1'b0, packet_issue = 1'b0;
    reg  [3:0]  int_num = 4'h9, wr_valid = 4'h0, wr_annul = 4'h0, wr_pred_annul = 4'h0;
    reg  [23:0] wr_dest = 24'h0;
    reg  [15:0] task_state = 16'h000C;
    // observed
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        annul, handler_enter, exc_take, loop_resume, loop_early_exit, irq;
    integer     fail_count = 0, samples_checked = 0, ex, alen, res, k;
    reg  [31:0] rv;
    reg  [1:0]  rr;
    typedef struct {
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0]  r;
    } row_t;
    // writable places keep the write; read-only and unmapped places must not take it
    row_t rows [6] = '{'{8'h14, VEC, VEC, `RESP_OKAY}, '{8'h18, 32'h0, 32'h0, `RESP_OKAY},
        '{8'h20, 32'h7, 32'h7, `RESP_OKAY}, '{8'h00, 32'hFFFF, 32'h0, `RESP_OKAY},
        '{8'h0C, 32'h2, 32'h0, `RESP_OKAY}, '{8'h40, 32'h5, 32'h0, `RESP_SLVERR}};

    always #25 aclk = ~aclk;

    exc_unit #(.DRAIN_CYCLES(DC)) uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .int_req, .int_num, .int_return, .pc,
        .task_state, .wr_valid, .wr_dest, .wr_annul, .wr_pred_annul, .loop_active,
        .loop_kernel_marker, .loop_start, .packet_issue, .annul,
        .handler_enter, .exc_take, .loop_resume, .loop_early_exit, .irq
    );

    // ======================================================================
    // tasks
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task tmo;
        fail_count++;
        $display("wrong value wait expected done seen timeout");
        end_of_test();
    endtask

    task automatic wr(input [7:0] a, input [31:0] d);
        integer i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        s_axi_bready <= 1'b0;
        if (i == 40)
            tmo();
    endtask

    task automatic rd(input [7:0] a);
        integer i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (i == 40)
            tmo();
    endtask

    // interrupt, annulled conflicting writes mid-drain, then return
    task automatic drain(input integer g);
        integer i;
        ex = 0;
        res = 0;
        @(posedge aclk);
        int_req <= 1'b1;
        for (i = 0; i < 20 && !annul; i++)
            @(posedge aclk);
        int_req <= 1'b0;
        wr_valid <= 4'h3;
        wr_dest <= 24'h000145;
        wr_annul <= 4'h3;
        wr_pred_annul <= 4'h3;
        alen = 1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            wr_valid <= 4'h0;
            alen += annul;
            ex += exc_take;
            if (handler_enter)
                break;
        end
        if (i == 20)
            tmo();
        loop_kernel_marker <= 1'b1;
        packet_issue <= 1'b1;
        @(posedge aclk);
        loop_kernel_marker <= 1'b0;
        repeat (g) @(posedge aclk);
        loop_start <= 1'b1;
        @(posedge aclk);
        loop_start <= 1'b0;
        int_return <= 1'b1;
        @(posedge aclk);
        int_return <= 1'b0;
        res += 2 * loop_early_exit;
        repeat (8) begin
            @(posedge aclk);
            res += loop_resume;
        end
    endtask

    // ======================================================================
    // sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("annul after reset", 32'h0, annul);
        chk("irq after reset", 32'h0, irq);
        for (k = 0; k < 16; k += 4) begin
            rd(k[7:0]);
            chk("reset register", 32'h0, rv);
        end
        foreach (rows[j]) begin
            wr(rows[j].a, rows[j].d);
            rd(rows[j].a);
            chk("read back", rows[j].e, rv);
            chk("read response", rows[j].r, rr);
        end
        // genuine conflict in normal flow
        @(posedge aclk);
        wr_valid <= 4'h3;
        wr_dest <= 24'h000145;
        ex = 0;
        repeat (6) begin
            @(posedge aclk);
            wr_valid <= 4'h0;
            ex += exc_take;
        end
        chk("run exception", 32'h1, ex);
        rd(`OFS_REPORT);
        chk("report", 32'h2, rv);
        rd(`OFS_FLAGS);
        chk("flags", 32'h2, rv);
        rd(`OFS_RETURN_PTR);
        chk("return pointer", pc, rv);
        chk("irq raised", 32'h1, irq);
        rd(`OFS_IRQ_STATUS);
        chk("irq status", 32'h1, rv);
        repeat (2) @(posedge aclk);
        chk("irq cleared", 32'h0, irq);
        wr(`OFS_CLEAR, `CLEAR_IXF_VALUE);
        rd(`OFS_FLAGS);
        chk("flags cleared", 32'h0, rv);
        // corrected mode, loop interrupted
        loop_active <= 1'b1;
        drain(0);
        chk("annulled writes ignored", 32'h0, ex);
        chk("drain length", DC, alen);
        chk("loop resumed", 32'h1, res);
        // faulty mode, interrupt masked
        wr(`OFS_CONTROL, 32'h1);
        wr(`OFS_IRQ_MASK, 32'h0);
        drain(0);
        chk("false exception", 32'h1, ex);
        chk("early end", 32'h2, res);
        chk("irq masked", 32'h0, irq);
        drain(2);
        chk("spaced resume", 32'h1, res);
        rd(`OFS_TASK_STATE);
        chk("saved task state", 32'h10, rv);
        rd(`OFS_RETURN_PTR);
        chk("handler pointer", VEC | 32'h120, rv);
        chk("masked pointer", VEC & `RETURN_MASK, rv & `RETURN_MASK);
        rd(`OFS_REPORT);
        chk("drain report", 32'h2, rv);
        rd(`OFS_FLAGS);
        chk("drain flags", 32'h2, rv);
        end_of_test();
    end
endmodule // tb_exc_unit
